// ==== rtl/emps_mdio_if.sv ====
// command carrier between register logic and the management engine
`timescale 1ns/1ns
interface emps_mdio_if;
   logic start;
   logic isRead;
   logic [4:0] phyAddr;
   logic [4:0] regAddr;
   logic [15:0] wrData;
   logic busy;
   logic [15:0] rdData;
   modport host (output start, isRead, phyAddr, regAddr, wrData, input busy, rdData);
   modport engine (input start, isRead, phyAddr, regAddr, wrData, output busy, rdData);
endinterface : emps_mdio_if

// ==== rtl/emps_mdio_shift.sv ====
// management frame serialiser with divided management clock
`timescale 1ns/1ns
module emps_mdio_shift (
   input wire logic clk,
   input wire logic reset,
   emps_mdio_if.engine cmd,
   output logic mdc,
   output logic mdioOut,
   output logic mdioOen,
   input wire logic mdioIn
);
   import emps_pkg::*;

   emps_md_state_t state_q, state_d;
   logic [4:0] cnt_q, cnt_d;
   logic [6:0] bitIdx_q, bitIdx_d;
   logic [63:0] shift_q, shift_d;
   logic isRead_q, isRead_d;
   logic [15:0] rd_q, rd_d;
   logic mdc_q, mdc_d;
   logic out_q, out_d;
   logic oen_q, oen_d;
   logic inS1_q, inS2_q;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      bitIdx_d = bitIdx_q;
      shift_d = shift_q;
      isRead_d = isRead_q;
      rd_d = rd_q;
      mdc_d = mdc_q;
      out_d = out_q;
      oen_d = oen_q;
      case (state_q)
         EMPS_MD_IDLE: begin
            if (cmd.start) begin
               isRead_d = cmd.isRead;
               shift_d = {MDIO_PREAMBLE, MDIO_ST, cmd.isRead ? MDIO_OP_READ : MDIO_OP_WRITE,
                          cmd.phyAddr, cmd.regAddr,
                          cmd.isRead ? 18'h3FFFF : {MDIO_TA_WRITE, cmd.wrData}};
               bitIdx_d = 7'h00;
               cnt_d = 5'h00;
               state_d = EMPS_MD_LOW;
               mdc_d = 1'b0;
               out_d = shift_d[63];
               oen_d = 1'b0;
            end
         end
         EMPS_MD_LOW: begin
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == MDC_HALF - 5'h01) begin
               cnt_d = 5'h00;
               mdc_d = 1'b1;
               state_d = EMPS_MD_HIGH;
               if (isRead_q && bitIdx_q >= MDIO_DATA_AT) begin
                  rd_d = {rd_q[14:0], inS2_q};
               end
            end
         end
         EMPS_MD_HIGH: begin
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == MDC_HALF - 5'h01) begin
               cnt_d = 5'h00;
               mdc_d = 1'b0;
               if (bitIdx_q == MDIO_LAST_BIT) begin
                  state_d = EMPS_MD_IDLE;
                  oen_d = 1'b1;
                  out_d = 1'b1;
               end else begin
                  bitIdx_d = bitIdx_q + 7'h01;
                  shift_d = {shift_q[62:0], 1'b0};
                  out_d = shift_q[62];
                  oen_d = isRead_q && (bitIdx_d >= MDIO_RELEASE_AT);
                  state_d = EMPS_MD_LOW;
               end
            end
         end
         default: begin
            state_d = EMPS_MD_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      inS1_q <= mdioIn;
      inS2_q <= inS1_q;
      if (reset) begin
         state_q <= EMPS_MD_IDLE;
         cnt_q <= 5'h00;
         bitIdx_q <= 7'h00;
         shift_q <= 64'h0000000000000000;
         isRead_q <= 1'b0;
         rd_q <= 16'h0000;
         mdc_q <= 1'b0;
         out_q <= 1'b1;
         oen_q <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         bitIdx_q <= bitIdx_d;
         shift_q <= shift_d;
         isRead_q <= isRead_d;
         rd_q <= rd_d;
         mdc_q <= mdc_d;
         out_q <= out_d;
         oen_q <= oen_d;
      end
   end

   assign cmd.busy = (state_q != EMPS_MD_IDLE);
   assign cmd.rdData = rd_q;
   assign mdc = mdc_q;
   assign mdioOut = out_q;
   assign mdioOen = oen_q;

endmodule : emps_mdio_shift

// ==== rtl/emps_pkg.sv ====
// shared constants, register map and types of the ethernet port signal block
package emps_pkg;

   // ---------------------------------------------------------------
   // clocking
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int MDC_MAX_HZ = 2_500_000;
   localparam int MDC_DIV = (CLK_HZ + MDC_MAX_HZ - 1) / MDC_MAX_HZ;
   localparam logic [4:0] MDC_HALF = 5'((MDC_DIV + 1) / 2);
   localparam int RATE_10_HZ = 2_500_000;
   localparam int RATE_100_HZ = 25_000_000;
   localparam int RATE_1000_HZ = 125_000_000;
   localparam int HALF_10_I = CLK_HZ / (2 * RATE_10_HZ);
   localparam int HALF_100_I = CLK_HZ / (2 * RATE_100_HZ);
   localparam int HALF_1000_I = CLK_HZ / (2 * RATE_1000_HZ);
   localparam logic [7:0] HALF_10 = 8'((HALF_10_I < 1) ? 1 : HALF_10_I);
   localparam logic [7:0] HALF_100 = 8'((HALF_100_I < 1) ? 1 : HALF_100_I);
   localparam logic [7:0] HALF_1000 = 8'((HALF_1000_I < 1) ? 1 : HALF_1000_I);

   // ---------------------------------------------------------------
   // ports and register map
   // ---------------------------------------------------------------
   localparam int PORTS = 2;
   localparam logic [3:0] REG_CONFIG = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_MDIO_CMD = 4'h8;
   localparam logic [3:0] REG_MDIO_STAT = 4'hC;
   localparam int CFG_SPEED_LSB = 0;
   localparam int CFG_FULL_DUPLEX = 2;
   localparam logic [2:0] CFG_RESET = 3'h0;
   localparam int STS_CARRIER_LSB = 0;
   localparam int STS_COLL_LSB = 8;
   localparam int STS_ECC_LSB = 16;
   localparam int CMD_DATA_LSB = 0;
   localparam int CMD_REG_LSB = 16;
   localparam int CMD_PHY_LSB = 21;
   localparam int CMD_READ = 26;
   localparam int CMD_START = 31;
   localparam int MST_BUSY = 16;

   typedef enum logic [1:0] {
      EMPS_SPD_10 = 2'b00,
      EMPS_SPD_100 = 2'b01,
      EMPS_SPD_1000 = 2'b10
   } emps_speed_t;

   // ---------------------------------------------------------------
   // ecc codes, receive error vector, framing
   // ---------------------------------------------------------------
   localparam logic [1:0] ECC_NONE = 2'b00;
   localparam logic [1:0] ECC_INVALID = 2'b01;
   localparam int ERR_COLLISION = 4;
   localparam int ERR_PHY = 3;
   localparam int ERR_TRUNC = 2;
   localparam logic [7:0] SFD_BYTE = 8'hD5;

   // ---------------------------------------------------------------
   // management frame
   // ---------------------------------------------------------------
   localparam logic [6:0] MDIO_LAST_BIT = 7'h3F;
   localparam logic [6:0] MDIO_RELEASE_AT = 7'h2E;
   localparam logic [6:0] MDIO_DATA_AT = 7'h30;
   localparam logic [31:0] MDIO_PREAMBLE = 32'hFFFFFFFF;
   localparam logic [1:0] MDIO_ST = 2'b01;
   localparam logic [1:0] MDIO_OP_READ = 2'b10;
   localparam logic [1:0] MDIO_OP_WRITE = 2'b01;
   localparam logic [1:0] MDIO_TA_WRITE = 2'b10;

   typedef enum logic [1:0] {
      EMPS_MD_IDLE = 2'b00,
      EMPS_MD_LOW = 2'b01,
      EMPS_MD_HIGH = 2'b10
   } emps_md_state_t;

   typedef struct packed {
      logic inFrame;
      logic sfdSeen;
      logic first;
      logic dropping;
      logic hiNib;
      logic [3:0] nibLo;
      logic pend;
      logic [7:0] pendByte;
      logic pendSop;
      logic [4:0] err;
      logic outValid;
      logic [7:0] outData;
      logic outSop;
      logic outEop;
      logic [4:0] outErr;
   } emps_rx_t;

endpackage : emps_pkg

// ==== rtl/emps_top.sv ====
// ethernet port signal block: mii status, receive stream, management port, ecc status
// How it works
// - a receive error from the phy marks the frame in progress as errored
// - collision input counts only at half duplex below gigabit
// - carrier sense shows line activity, ignored at full duplex or gigabit
// - management data enable is active low; high releases the pin for input
// - management clock is the bus clock divided so it stays at or under 2.5 MHz
// - one management bit moves per falling management clock edge
// - every management field goes most significant bit first
// - ecc status codes 11 uncorrectable, 10 corrected, 00 none, 01 never shown
// - ecc status passes a two stage synchroniser before output
// - each port gets a receive clock set by link speed
// - each port gets a transmit clock set by link speed
// - receive valid only when data, start, end and error are meaningful
// - start flag rides the valid cycle of the first frame byte
// - end flag rides the valid cycle of the last frame byte
// - not ready never stalls: frame dropped or truncated with error
// - error vector is driven with the final byte of the frame
// - error bits 4..2 follow collision, phy error, truncation order
`timescale 1ns/1ns
module emps_top (
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [emps_pkg::PORTS-1:0][3:0] miiRxData,
   input wire logic [emps_pkg::PORTS-1:0] miiRxDv,
   input wire logic [emps_pkg::PORTS-1:0] miiRxErr,
   input wire logic [emps_pkg::PORTS-1:0] miiCol,
   input wire logic [emps_pkg::PORTS-1:0] miiCrs,
   output logic mdc,
   output logic mdioOut,
   output logic mdioOen,
   input wire logic mdioIn,
   input wire logic [1:0] eccRaw,
   output logic [1:0] eccStatus,
   output logic [emps_pkg::PORTS-1:0] macRxClk,
   output logic [emps_pkg::PORTS-1:0] macTxClk,
   output logic [emps_pkg::PORTS-1:0] rxValid,
   output logic [emps_pkg::PORTS-1:0][7:0] rxData,
   output logic [emps_pkg::PORTS-1:0] rxSop,
   output logic [emps_pkg::PORTS-1:0] rxEop,
   output logic [emps_pkg::PORTS-1:0][4:0] rxError,
   input wire logic [emps_pkg::PORTS-1:0] rxReady
);
   import emps_pkg::*;

   emps_mdio_if mdioCmd ();

   logic ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic [2:0] cfg_q, cfg_d;
   logic [1:0] eccS1_q, eccS2_q, ecc_q, ecc_d;
   logic [7:0] div_q, div_d;
   logic pclk_q, pclk_d;
   logic tick;
   logic [7:0] half;
   logic fullDup, gig;
   logic [PORTS-1:0] carrier, collision;
   logic busWrite;

   assign fullDup = cfg_q[CFG_FULL_DUPLEX];
   assign gig = (cfg_q[CFG_SPEED_LSB +: 2] == EMPS_SPD_1000);

   // ---------------------------------------------------------------
   // register bus slave
   // ---------------------------------------------------------------
   assign waitrequest = (read || write) && !ack_q;
   assign busWrite = write && ack_q;

   always_comb begin
      ack_d = (read || write) && !ack_q;
      rdata_d = rdata_q;
      cfg_d = cfg_q;
      if (read && !ack_q) begin
         rdata_d = 32'h00000000;
         case (address)
            REG_CONFIG: rdata_d[2:0] = cfg_q;
            REG_STATUS: begin
               rdata_d[STS_CARRIER_LSB +: PORTS] = carrier;
               rdata_d[STS_COLL_LSB +: PORTS] = collision;
               rdata_d[STS_ECC_LSB +: 2] = ecc_q;
            end
            REG_MDIO_STAT: begin
               rdata_d[15:0] = mdioCmd.rdData;
               rdata_d[MST_BUSY] = mdioCmd.busy;
            end
            default: rdata_d = 32'h00000000;
         endcase
      end
      if (busWrite && address == REG_CONFIG) begin
         cfg_d = writedata[2:0];
      end
   end

   assign mdioCmd.start = busWrite && (address == REG_MDIO_CMD) && writedata[CMD_START] && !mdioCmd.busy;
   assign mdioCmd.isRead = writedata[CMD_READ];
   assign mdioCmd.phyAddr = writedata[CMD_PHY_LSB +: 5];
   assign mdioCmd.regAddr = writedata[CMD_REG_LSB +: 5];
   assign mdioCmd.wrData = writedata[CMD_DATA_LSB +: 16];

   always_ff @(posedge clk) begin
      if (reset) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h00000000;
         cfg_q <= CFG_RESET;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         cfg_q <= cfg_d;
      end
   end

   assign readdata = rdata_q;

   // ---------------------------------------------------------------
   // management engine
   // ---------------------------------------------------------------
   emps_mdio_shift mdioEngine (
      .clk(clk),
      .reset(reset),
      .cmd(mdioCmd.engine),
      .mdc(mdc),
      .mdioOut(mdioOut),
      .mdioOen(mdioOen),
      .mdioIn(mdioIn)
   );

   // ---------------------------------------------------------------
   // ecc status
   // ---------------------------------------------------------------
   always_comb begin
      ecc_d = (eccS2_q == ECC_INVALID) ? ECC_NONE : eccS2_q;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         eccS1_q <= ECC_NONE;
         eccS2_q <= ECC_NONE;
         ecc_q <= ECC_NONE;
      end else begin
         eccS1_q <= eccRaw;
         eccS2_q <= eccS1_q;
         ecc_q <= ecc_d;
      end
   end

   assign eccStatus = ecc_q;

   // ---------------------------------------------------------------
   // port clock divider
   // ---------------------------------------------------------------
   always_comb begin
      case (cfg_q[CFG_SPEED_LSB +: 2])
         EMPS_SPD_100: half = HALF_100;
         EMPS_SPD_1000: half = HALF_1000;
         default: half = HALF_10;
      endcase
      div_d = div_q + 8'h01;
      pclk_d = pclk_q;
      tick = 1'b0;
      if (div_q >= half - 8'h01) begin
         div_d = 8'h00;
         pclk_d = !pclk_q;
         tick = !pclk_q;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         div_q <= 8'h00;
         pclk_q <= 1'b0;
      end else begin
         div_q <= div_d;
         pclk_q <= pclk_d;
      end
   end

   // ---------------------------------------------------------------
   // per port mii status and receive stream
   // ---------------------------------------------------------------
   for (genvar p = 0; p < PORTS; p++) begin : gPort
      emps_rx_t r_q, r_d;
      logic [7:0] syncS1_q, syncS2_q;
      logic rxDv, rxEr, rxCol, rxCrs;
      logic [3:0] rxNib;

      always_ff @(posedge clk) begin
         syncS1_q <= {miiRxDv[p], miiRxErr[p], miiCol[p], miiCrs[p], miiRxData[p]};
         syncS2_q <= syncS1_q;
      end
      assign {rxDv, rxEr, rxCol, rxCrs, rxNib} = syncS2_q;

      assign carrier[p] = rxCrs && !fullDup && !gig;
      assign collision[p] = rxCol && !fullDup && !gig;
      assign macRxClk[p] = pclk_q;
      assign macTxClk[p] = pclk_q;

      always_comb begin
         logic emit;
         logic [7:0] eByte;
         logic eSop;
         logic eEop;
         logic [7:0] asm;
         emit = 1'b0;
         eByte = 8'h00;
         eSop = 1'b0;
         eEop = 1'b0;
         asm = {rxNib, r_q.nibLo};
         r_d = r_q;
         if (tick) begin
            r_d.outValid = 1'b0;
            r_d.outSop = 1'b0;
            r_d.outEop = 1'b0;
            r_d.outErr = 5'h00;
            if (rxDv) begin
               if (!r_q.inFrame) begin
                  r_d.inFrame = 1'b1;
                  r_d.sfdSeen = 1'b0;
                  r_d.first = 1'b1;
                  r_d.dropping = 1'b0;
                  r_d.hiNib = 1'b0;
                  r_d.pend = 1'b0;
                  r_d.err = 5'h00;
               end
               r_d.err[ERR_PHY] = r_d.err[ERR_PHY] | rxEr;
               r_d.err[ERR_COLLISION] = r_d.err[ERR_COLLISION] | collision[p];
               if (!r_d.hiNib) begin
                  r_d.nibLo = rxNib;
                  r_d.hiNib = 1'b1;
               end else begin
                  r_d.hiNib = 1'b0;
                  if (!r_q.sfdSeen) begin
                     r_d.sfdSeen = (asm == SFD_BYTE);
                  end else begin
                     emit = r_q.pend;
                     eByte = r_q.pendByte;
                     eSop = r_q.pendSop;
                     r_d.pend = 1'b1;
                     r_d.pendByte = asm;
                     r_d.pendSop = r_q.first;
                     r_d.first = 1'b0;
                  end
               end
            end else if (r_q.inFrame) begin
               r_d.inFrame = 1'b0;
               r_d.pend = 1'b0;
               emit = r_q.pend;
               eByte = r_q.pendByte;
               eSop = r_q.pendSop;
               eEop = 1'b1;
            end
            if (emit && !r_q.dropping) begin
               if (!rxReady[p] && eSop) begin
                  r_d.dropping = 1'b1;
               end else begin
                  r_d.outValid = 1'b1;
                  r_d.outData = eByte;
                  r_d.outSop = eSop;
                  r_d.outEop = eEop || !rxReady[p];
                  if (eEop || !rxReady[p]) begin
                     r_d.outErr = r_d.err;
                     r_d.outErr[ERR_TRUNC] = !rxReady[p] && !eEop;
                     r_d.dropping = !eEop;
                  end
               end
            end
         end
      end

      always_ff @(posedge clk) begin
         if (reset) begin
            r_q <= '0;
         end else begin
            r_q <= r_d;
         end
      end

      assign rxValid[p] = r_q.outValid;
      assign rxData[p] = r_q.outData;
      assign rxSop[p] = r_q.outSop;
      assign rxEop[p] = r_q.outEop;
      assign rxError[p] = r_q.outErr;
   end

endmodule : emps_top

// ==== sim/emps_checker.sv ====
// concurrent checks on the ports of the ethernet port signal block
`timescale 1ns/1ns
module emps_checker (
   input logic clk,
   input logic reset,
   input logic mdc,
   input logic mdioOut,
   input logic mdioOen,
   input logic [1:0] eccRaw,
   input logic [1:0] eccStatus,
   input logic [emps_pkg::PORTS-1:0] macRxClk,
   input logic [emps_pkg::PORTS-1:0] macTxClk,
   input logic [emps_pkg::PORTS-1:0] rxValid,
   input logic [emps_pkg::PORTS-1:0] rxSop,
   input logic [emps_pkg::PORTS-1:0] rxEop,
   input logic [emps_pkg::PORTS-1:0][4:0] rxError
);
   import emps_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // ------
   // checks
   // ------
   chk_mdc_high: assert property ($rose(mdc) |-> mdc [*8] ##1 mdc [*2] ##1 !mdc)
      else $error("management clock high phase wrong");
   chk_frame_start: assert property ($fell(mdioOen) |-> !mdc [*8] ##1 !mdc [*2] ##1 mdc)
      else $error("frame start timing wrong");
   chk_out_on_fall: assert property (!mdioOen && $changed(mdioOut) |-> $fell(mdc))
      else $error("management data moved off the falling clock");
   chk_ecc_code: assert property (eccStatus != ECC_INVALID)
      else $error("invalid ecc code shown");
   chk_ecc_follow: assert property (eccRaw != ECC_INVALID ##1 $stable(eccRaw) [*3] |-> eccStatus == eccRaw)
      else $error("ecc status does not follow its input");
   chk_ctl_valid: assert property (rxSop[0] || rxEop[0] || rxError[0] != 5'h00 |-> rxValid[0])
      else $error("stream flags without valid");
   chk_err_on_eop: assert property (rxValid[0] && !rxEop[0] |-> rxError[0] == 5'h00)
      else $error("error vector off the final byte");
   chk_beat_edge: assert property ($changed(rxValid[0]) |-> $rose(macRxClk[0]))
      else $error("valid moved off the port clock edge");
   chk_rxclk_high: assert property ($rose(macRxClk[0]) |-> ##[1:10] !macRxClk[0])
      else $error("receive clock high too long");
   chk_txclk_high: assert property ($rose(macTxClk[0]) |-> ##[1:10] !macTxClk[0])
      else $error("transmit clock high too long");
   cover property (rxValid[0] && rxEop[0] && rxError[0] != 5'h00);
   cover property ($fell(mdioOen));
   cover property (eccStatus == 2'h3);
endmodule : emps_checker

// ==== sim/emps_phy_model.sv ====
// far-side model: mii receive source and management responder
`timescale 1ns/1ns
module emps_phy_model (
   input logic [emps_pkg::PORTS-1:0] macRxClk,
   input logic mdc,
   input logic mdioOut,
   input logic mdioOen,
   output logic mdioIn,
   output logic [emps_pkg::PORTS-1:0][3:0] miiRxData,
   output logic [emps_pkg::PORTS-1:0] miiRxDv,
   output logic [emps_pkg::PORTS-1:0] miiRxErr
);
   import emps_pkg::*;
   localparam logic [15:0] RD_VAL = 16'h9C61;
   logic [63:0] seen = 64'h0;
   logic [6:0] cnt = 7'h0;
   logic isRd = 1'h0;
   logic drv = 1'h0;
   logic bitv = 1'h1;
   initial begin
      miiRxData = '0;
      miiRxDv = '0;
      miiRxErr = '0;
   end
   // released pin is pulled up
   assign mdioIn = mdioOen ? (drv ? bitv : 1'h1) : mdioOut;
   always @(posedge mdc, negedge mdioOen) begin
      if (!mdc) begin
         cnt <= 7'h0;
      end else begin
         seen <= {seen[62:0], mdioIn};
         cnt <= cnt + 7'h1;
         if (cnt == 7'h23) isRd <= seen[0] & ~mdioIn;
         drv <= isRd && cnt >= 7'h2E && cnt <= 7'h3E;
         bitv <= (cnt == 7'h2E) ? 1'h0 : RD_VAL[7'h3E - cnt];
      end
   end
   task automatic nib(input int p, input logic [3:0] d, input logic v, input logic e);
      @(posedge macRxClk[p]);
      miiRxData[p] <= d;
      miiRxDv[p] <= v;
      miiRxErr[p] <= e;
   endtask : nib
   task automatic send(input int p, input int n, input int errAt);
      logic [7:0] b;
      b = 8'h00;
      for (int i = 0; i < 4; i++) nib(p, i == 3 ? 4'hD : 4'h5, 1'h1, 1'h0);
      for (int i = 0; i < 2 * n; i++) begin
         b = 8'hA0 + 8'(i / 2);
         nib(p, i % 2 ? b[7:4] : b[3:0], 1'h1, i / 2 == errAt);
      end
      nib(p, ~b[7:4], 1'h0, 1'h0);
   endtask : send
endmodule : emps_phy_model

// ==== sim/emps_tb_top.sv ====
// self-checking bench of the ethernet port signal block
`timescale 1ns/1ns
module emps_tb_top;
   import emps_pkg::*;
   logic clk, reset, read, write, waitrequest, mdc, mdioOut, mdioOen, mdioIn;
   logic [3:0] address;
   logic [31:0] writedata, readdata, q;
   logic [1:0] eccRaw, eccStatus;
   logic [PORTS-1:0] miiRxDv, miiRxErr, miiCol, miiCrs, macRxClk, macTxClk, rxValid, rxSop, rxEop, rxReady;
   logic [PORTS-1:0][3:0] miiRxData;
   logic [PORTS-1:0][7:0] rxData;
   logic [PORTS-1:0][4:0] rxError;
   logic [14:0] beats[$];
   int miscompares = 0;
   int cmpCount = 0;
   int cyc = 0;

   emps_top dut_u (.clk, .reset, .address, .read, .write, .writedata, .readdata, .waitrequest, .miiRxData,
      .miiRxDv, .miiRxErr, .miiCol, .miiCrs, .mdc, .mdioOut, .mdioOen, .mdioIn, .eccRaw, .eccStatus, .macRxClk,
      .macTxClk, .rxValid, .rxData, .rxSop, .rxEop, .rxError, .rxReady);
   emps_phy_model phy_u (.macRxClk, .mdc, .mdioOut, .mdioOen, .mdioIn, .miiRxData, .miiRxDv, .miiRxErr);

   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         miscompares++;
         print_verdict();
      end
   end
   // beats are taken mid period, only while valid
   always @(negedge macRxClk[0]) begin
      if (rxValid[0] === 1'h1) beats.push_back({rxError[0], rxSop[0], rxEop[0], rxData[0]});
   end
   // ------
   // tasks
   // ------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmpCount++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= ~wr;
      write <= wr;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'h0 && n < 50);
      if (waitrequest !== 1'h0) miscompares++;
      q = readdata;
      read <= 1'h0;
      write <= 1'h0;
   endtask : bus
   task automatic mdio(input logic [31:0] cmd);
      int n;
      n = 0;
      bus(1'h1, REG_MDIO_CMD, cmd);
      do begin
         bus(1'h0, REG_MDIO_STAT, 32'h0);
         n++;
      end while (q[MST_BUSY] !== 1'h0 && n < 1000);
      if (q[MST_BUSY] !== 1'h0) miscompares++;
   endtask : mdio
   task automatic rx(input int n, input int errAt, input logic cut, input int nExp, input logic [4:0] eErr);
      beats.delete();
      fork
         phy_u.send(0, n, errAt);
         if (cut) begin
            wait (beats.size() == 1);
            @(posedge clk);
            rxReady[0] <= 1'h0;
         end
      join
      repeat (80) @(posedge clk);
      rxReady <= '1;
      chk(beats.size(), nExp);
      for (int i = 0; i < nExp; i++) begin
         chk(beats[i], {i == nExp - 1 ? eErr : 5'h00, i == 0, i == nExp - 1, 8'hA0 + 8'(i)});
      end
   endtask : rx
   task automatic t_reset;
      chk({mdc, mdioOen, mdioOut, eccStatus, rxValid}, {1'h0, 1'h1, 1'h1, 2'h0, {PORTS{1'h0}}});
   endtask : t_reset
   task automatic t_status;
      miiCrs <= 2'h3;
      miiCol <= 2'h2;
      for (int i = 0; i < 3; i++) begin
         bus(1'h1, REG_CONFIG, i == 0 ? 32'h0 : (i == 1 ? 32'h4 : 32'h2));
         repeat (4) @(posedge clk);
         bus(1'h0, REG_STATUS, 32'h0);
         chk(q[9:0], i == 0 ? 10'h203 : 10'h000);
      end
      bus(1'h0, 4'h2, 32'h0);
      chk(q, 32'h0);
      miiCrs <= 2'h0;
      miiCol <= 2'h0;
   endtask : t_status
   task automatic t_ecc;
      logic [1:0] c;
      for (int i = 0; i < 4; i++) begin
         c = 2'(3 - i);
         eccRaw <= c;
         repeat (5) @(posedge clk);
         chk(eccStatus, c == 2'h1 ? 2'h0 : c);
      end
   endtask : t_ecc
   task automatic t_clocks;
      time t0;
      for (int i = 0; i < 3; i++) begin
         bus(1'h1, REG_CONFIG, 32'(i));
         repeat (40) @(posedge clk);
         @(posedge macRxClk[0]);
         t0 = $time;
         @(posedge macRxClk[0]);
         chk(($time - t0) / 20, i == 0 ? 20 : 2);
         @(posedge macTxClk[1]);
         t0 = $time;
         @(posedge macTxClk[1]);
         chk(($time - t0) / 20, i == 0 ? 20 : 2);
      end
   endtask : t_clocks
   task automatic t_rx_good;
      bus(1'h1, REG_CONFIG, 32'h1);
      rx(3, -1, 1'h0, 3, 5'h00);
      rx(1, -1, 1'h0, 1, 5'h00);
   endtask : t_rx_good
   task automatic t_rx_err;
      rx(3, 1, 1'h0, 3, 5'h08);
   endtask : t_rx_err
   task automatic t_rx_ready;
      rx(4, -1, 1'h1, 2, 5'h04);
      @(posedge clk);
      rxReady[0] <= 1'h0;
      rx(3, -1, 1'h0, 0, 5'h00);
   endtask : t_rx_ready
   task automatic t_rx_col;
      bus(1'h1, REG_CONFIG, 32'h0);
      miiCol[0] <= 1'h1;
      rx(1, -1, 1'h0, 1, 5'h10);
      bus(1'h1, REG_CONFIG, 32'h4);
      rx(1, -1, 1'h0, 1, 5'h00);
      miiCol[0] <= 1'h0;
   endtask : t_rx_col
   task automatic t_mdio;
      mdio({1'h1, 4'h0, 1'h0, 5'h13, 5'h0A, 16'hC3A5});
      chk(phy_u.seen, {32'hFFFFFFFF, 2'h1, 2'h1, 5'h13, 5'h0A, 2'h2, 16'hC3A5});
      mdio({1'h1, 4'h0, 1'h1, 5'h01, 5'h1F, 16'h0000});
      chk(q[15:0], 16'h9C61);
      chk(phy_u.seen, {32'hFFFFFFFF, 2'h1, 2'h2, 5'h01, 5'h1F, 2'h2, 16'h9C61});
   endtask : t_mdio
   task automatic print_verdict;
      if (miscompares == 0 && cmpCount > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict
   initial begin
      reset = 1'h1;
      read = 1'h0;
      write = 1'h0;
      address = 4'h0;
      writedata = 32'h0;
      eccRaw = 2'h0;
      miiCol = 2'h0;
      miiCrs = 2'h0;
      rxReady = '1;
      repeat (4) @(posedge clk);
      reset <= 1'h0;
      @(posedge clk);
      t_reset();
      t_status();
      t_ecc();
      t_clocks();
      t_rx_good();
      t_rx_err();
      t_rx_ready();
      t_rx_col();
      t_mdio();
      print_verdict();
   end
endmodule : emps_tb_top

bind emps_top emps_checker chk_u (.clk, .reset, .mdc, .mdioOut, .mdioOen, .eccRaw, .eccStatus, .macRxClk,
   .macTxClk, .rxValid, .rxSop, .rxEop, .rxError);
